// ### logic/fxpcs_rx.sv
// Contract
// - line bits go from NRZI to NRZ before anything else
// - converted stream is unaligned; boundaries found later
// - lock de-scrambler after idle burst of 40 bits, load LFSR
// - once locked, XOR each bit with the deciphering keystream
// - start a 722 us hold timer when lock is reached
// - enough idles before expiry reload the timer, forever
// - too few idles within hold period drop and reset lock
// - aligner searches the unaligned de-scrambled stream for J/K
// - on 11000 then 10001 fix the 5-bit boundary
// - decode each aligned 5-bit group to a nibble by table
// - J/K after idle is output as preamble nibbles
// - translate packet groups until T then R is seen
// - nibble on 4-bit bus, bit 0 is the lsb
// - pass 6-bit line samples on toward equalizer each cycle
// - 10 Mbit/s loopback path for diagnostics
// - each coding stage can be bypassed
// - data valid from first J/K nibble until T/R or lock loss
// - with data valid, error for every unmapped code group
// - carrier without J/K: error and 1110 until two idles
// - carrier on two non-adjacent zeros in any 10-bit window
`timescale 1ns/10ps
`include "fxpcs_consts.svh"

module fxpcs_fifo #(
  parameter int W = `FXPCS_FIFO_W,
  parameter int D = `FXPCS_FIFO_D
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side, registered
  output logic              out_valid_r,
  output logic [W-1:0]      out_data_r,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;
  wire          empty = (wr_r == rd_r);
  wire          full  = (wr_r[AW] != rd_r[AW]) &&
                        (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire          push  = in_valid && !full;
  // refill output stage when it is empty or being taken
  wire          load  = !empty && (!out_valid_r || out_ready);

  assign in_ready = !full;

  // storage has no reset; pointers guard it
  always_ff @(posedge clk) begin
    if (push)
      mem[wr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_r        <= '0;
      rd_r        <= '0;
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (load) begin
        rd_r        <= rd_r + 1'b1;
        out_data_r  <= mem[rd_r[AW-1:0]];
        out_valid_r <= 1'b1;
      end else if (out_ready)
        out_valid_r <= 1'b0;
    end
  end
endmodule : fxpcs_fifo

module fxpcs_rx #(
  parameter int   HOLD_CYC = `FXPCS_HOLD_US * `FXPCS_CLK_MHZ,
  parameter logic [15:0] IDLE_MIN = `FXPCS_IDLE_MIN
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // recovered line, loopback source and converter samples
  input  wire logic                 line_bit,
  input  wire logic                 lb_bit,
  input  wire logic                 lb_en,
  input  wire logic [5:0]           adc_sample,
  output logic [5:0]                eq_sample_r,
  // stage bypass: nrzi, scrambler, decoder
  input  wire logic [2:0]           bypass,
  // status
  output logic                      lock_r,
  output logic                      crs_r,
  output logic                      overrun_r,
  // internal receive nibble stream
  output logic                      rx_valid_r,
  output fxpcs_pkg::fxpcs_nib_t     rx_data_r,
  output logic                      rx_dv_r,
  output logic                      rx_err_r,
  input  wire logic                 rx_ready
);
  import fxpcs_pkg::*;

  // 5b to {valid, nibble}
  function automatic logic [4:0] dec5(input logic [4:0] s);
    case (s)
      5'h1e:   dec5 = 5'h10;
      5'h09:   dec5 = 5'h11;
      5'h14:   dec5 = 5'h12;
      5'h15:   dec5 = 5'h13;
      5'h0a:   dec5 = 5'h14;
      5'h0b:   dec5 = 5'h15;
      5'h0e:   dec5 = 5'h16;
      5'h0f:   dec5 = 5'h17;
      5'h12:   dec5 = 5'h18;
      5'h13:   dec5 = 5'h19;
      5'h16:   dec5 = 5'h1a;
      5'h17:   dec5 = 5'h1b;
      5'h1a:   dec5 = 5'h1c;
      5'h1b:   dec5 = 5'h1d;
      5'h1c:   dec5 = 5'h1e;
      5'h1d:   dec5 = 5'h1f;
      default: dec5 = 5'h00;
    endcase
  endfunction : dec5

  // two zeros in the window that are not neighbours
  function automatic logic sep_zeros(input logic [9:0] w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++)
      for (int j = i + 2; j < 10; j++)
        if (!w[i] && !w[j])
          hit = 1'b1;
    return hit;
  endfunction : sep_zeros

  // pin synchroniser, first flop read only by the second
  logic sync1_r, sync2_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= line_bit;
      sync2_r <= sync1_r;
    end
  end

  // loopback replaces the line with the transmit bit
  wire  in_bit = lb_en ? lb_bit : sync2_r;
  logic prev_r;
  wire  nrz = bypass[`FXPCS_BYP_NRZI] ? in_bit
                                      : (in_bit ^ prev_r);

  // keystream history assumes idle; lock when it predicts itself
  logic [`FXPCS_LFSR_W-1:0] hist_r, lfsr_r;
  logic [5:0]  run_r;
  logic [15:0] hold_r, idles_r;
  logic [2:0]  ones_r;
  wire  ks_guess = ~nrz;
  wire  pred_ok  = ks_guess == (hist_r[`FXPCS_TAP_A] ^ hist_r[`FXPCS_TAP_B]);
  wire  ks_next  = lfsr_r[`FXPCS_TAP_A] ^ lfsr_r[`FXPCS_TAP_B];
  wire  lock_hit = !lock_r && pred_ok && (run_r == `FXPCS_LOCK_BITS - 1);
  wire  scr_bit  = bypass[`FXPCS_BYP_SCR] ? nrz
                   : (lock_r ? (nrz ^ ks_next) : 1'b0);
  wire  bit_ok   = lock_r || bypass[`FXPCS_BYP_SCR];
  wire  idle_sym = scr_bit && (ones_r == `FXPCS_LAST_PH);
  wire  enough   = idles_r >= IDLE_MIN;
  wire  expire   = lock_r && (hold_r == 16'h0000);

  // nrzi memory and keystream search
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_r <= 1'b0;
      hist_r <= '0;
      run_r  <= '0;
    end else begin
      prev_r <= in_bit;
      hist_r <= {hist_r[`FXPCS_LFSR_W-2:0], ks_guess};
      run_r  <= (pred_ok && !lock_r) ? run_r + 6'h01 : 6'h00;
    end
  end

  // lock, deciphering register and hold timer
  always_ff @(posedge clk) begin
    if (sys_rst || expire) begin
      lock_r  <= 1'b0;
      lfsr_r  <= '0;
      hold_r  <= '0;
      idles_r <= '0;
      ones_r  <= '0;
    end else if (lock_hit) begin
      lock_r  <= 1'b1;
      lfsr_r  <= {hist_r[`FXPCS_LFSR_W-2:0], ks_guess};
      hold_r  <= 16'(HOLD_CYC - 1);
      idles_r <= '0;
      ones_r  <= '0;
    end else if (lock_r) begin
      lfsr_r <= {lfsr_r[`FXPCS_LFSR_W-2:0], ks_next};
      ones_r <= (!scr_bit || idle_sym) ? 3'h0 : ones_r + 3'h1;
      if (enough) begin
        hold_r  <= 16'(HOLD_CYC - 1);
        idles_r <= '0;
      end else begin
        hold_r  <= hold_r - 16'h0001;
        idles_r <= idles_r + {15'h0000, idle_sym};
      end
    end
  end

  // unaligned window feeds aligner and carrier sense
  logic [`FXPCS_WIN_W+`FXPCS_SYM_W-1:0] win_r;
  wire  [`FXPCS_WIN_W-1:0] win_now = {win_r[`FXPCS_WIN_W-2:0], scr_bit};
  wire  jk_seen  = bit_ok && (win_now == `FXPCS_JK_PAIR);
  wire  after_id = win_r[`FXPCS_WIN_W+`FXPCS_SYM_W-2:`FXPCS_WIN_W-1]
                   == `FXPCS_SYM_IDLE;
  wire  cs_hit   = bit_ok && sep_zeros(win_now);
  wire  all_idle = win_now == '1;

  // symbol slicing
  fxpcs_state_t st_r;
  logic [2:0] ph_r;
  logic [3:0] ssd_r;
  logic [1:0] idl_r;
  logic       t_r;
  wire  [4:0] sym    = win_now[`FXPCS_SYM_W-1:0];
  wire        sym_ok = ph_r == `FXPCS_LAST_PH;
  wire  [4:0] dtab   = dec5(sym);
  wire        dec_ok = dtab[4] || bypass[`FXPCS_BYP_DEC];
  wire  [3:0] dnib   = bypass[`FXPCS_BYP_DEC] ? sym[3:0] : dtab[3:0];

  // word to push: {dv, err, nibble}
  logic       push;
  logic [5:0] word;
  logic       in_rdy;
  always_comb begin
    push = 1'b0;
    word = '0;
    case (st_r)
      FXPCS_IDLE:
        if (jk_seen && after_id) begin
          push = 1'b1;
          word = {2'b10, `FXPCS_NIB_PRE};
        end
      FXPCS_FRAME:
        if (sym_ok && !(sym == `FXPCS_SYM_T) && !t_r) begin
          push = 1'b1;
          word = {1'b1, !dec_ok, dnib};
        end else if (sym_ok && t_r && sym != `FXPCS_SYM_R) begin
          push = 1'b1;
          word = {2'b11, dnib};
        end
      FXPCS_BADSSD:
        if (sym_ok) begin
          push = 1'b1;
          word = {2'b01, `FXPCS_NIB_BAD};
        end
      default: begin
        push = 1'b0;
        word = '0;
      end
    endcase
  end

  // framing state; a lock loss ends the frame
  always_ff @(posedge clk) begin
    if (sys_rst || !bit_ok) begin
      st_r  <= FXPCS_IDLE;
      win_r <= '1;
      ph_r  <= '0;
      ssd_r <= '0;
      idl_r <= '0;
      t_r   <= 1'b0;
      crs_r <= 1'b0;
    end else begin
      win_r <= {win_r[`FXPCS_WIN_W+`FXPCS_SYM_W-2:0], scr_bit};
      ph_r  <= sym_ok ? 3'h0 : ph_r + 3'h1;
      if (cs_hit)
        crs_r <= 1'b1;
      else if (all_idle && st_r == FXPCS_IDLE)
        crs_r <= 1'b0;
      case (st_r)
        FXPCS_IDLE: begin
          if (jk_seen && after_id) begin
            st_r  <= FXPCS_FRAME;
            ph_r  <= 3'h0;
            ssd_r <= '0;
          end else if (crs_r) begin
            ssd_r <= ssd_r + 4'h1;
            if (ssd_r == `FXPCS_SSD_WAIT) begin
              st_r  <= FXPCS_BADSSD;
              ph_r  <= 3'h0;
              idl_r <= '0;
            end
          end else
            ssd_r <= '0;
        end
        FXPCS_FRAME:
          if (sym_ok) begin
            if (t_r && sym == `FXPCS_SYM_R) begin
              st_r  <= FXPCS_IDLE;
              crs_r <= 1'b0;
            end
            t_r <= (sym == `FXPCS_SYM_T) && !t_r;
          end
        FXPCS_BADSSD:
          if (sym_ok) begin
            idl_r <= (sym == `FXPCS_SYM_IDLE) ? idl_r + 2'h1 : 2'h0;
            if (sym == `FXPCS_SYM_IDLE && idl_r == 2'h1) begin
              st_r  <= FXPCS_IDLE;
              crs_r <= 1'b0;
              ssd_r <= '0;
            end
          end
        default: st_r <= FXPCS_IDLE;
      endcase
    end
  end

  // converter samples and overrun; full fifo drops the nibble
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eq_sample_r <= '0;
      overrun_r   <= 1'b0;
    end else begin
      eq_sample_r <= adc_sample;
      if ((push || pre2_r) && !in_rdy)
        overrun_r <= 1'b1;
    end
  end

  // nibble buffer toward the receive side; preamble counted twice
  logic [5:0] fifo_q;
  logic       pre2_r;
  always_ff @(posedge clk) begin
    if (sys_rst)
      pre2_r <= 1'b0;
    else
      pre2_r <= push && st_r == FXPCS_IDLE && in_rdy;
  end

  fxpcs_fifo #(.W(`FXPCS_FIFO_W), .D(`FXPCS_FIFO_D)) u_fifo (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .in_valid    (push || pre2_r),
    .in_data     (pre2_r ? {2'b10, `FXPCS_NIB_PRE} : word),
    .in_ready    (in_rdy),
    .out_valid_r (rx_valid_r),
    .out_data_r  (fifo_q),
    .out_ready   (rx_ready)
  );

  assign rx_data_r = fifo_q[3:0];
  assign rx_err_r  = fifo_q[4];
  assign rx_dv_r   = fifo_q[5];
endmodule : fxpcs_rx

// ### inc/fxpcs_consts.svh
`ifndef FXPCS_CONSTS_SVH
`define FXPCS_CONSTS_SVH
// clock and hold timer
`define FXPCS_CLK_MHZ    10
`define FXPCS_HOLD_US    722
// de-scrambler: keystream length, taps, idle burst for lock
`define FXPCS_LFSR_W     11
`define FXPCS_TAP_A      10
`define FXPCS_TAP_B      8
`define FXPCS_LOCK_BITS  6'h28
`define FXPCS_IDLE_MIN   16'h0010
// code groups
`define FXPCS_SYM_W      5
`define FXPCS_WIN_W      10
`define FXPCS_JK_PAIR    10'h311
`define FXPCS_SYM_IDLE   5'h1f
`define FXPCS_SYM_T      5'h0d
`define FXPCS_SYM_R      5'h07
`define FXPCS_NIB_PRE    4'h5
`define FXPCS_NIB_BAD    4'he
`define FXPCS_SSD_WAIT   4'ha
`define FXPCS_LAST_PH    3'h4
// bypass select bits
`define FXPCS_BYP_NRZI   0
`define FXPCS_BYP_SCR    1
`define FXPCS_BYP_DEC    2
// fifo
`define FXPCS_FIFO_W     6
`define FXPCS_FIFO_D     16
`endif

// ### inc/fxpcs_pkg.sv
package fxpcs_pkg;
  // receive framing states
  typedef enum logic [1:0] {
    FXPCS_IDLE,
    FXPCS_FRAME,
    FXPCS_BADSSD
  } fxpcs_state_t;
  typedef logic [3:0] fxpcs_nib_t;
endpackage : fxpcs_pkg

// ### verification/fxpcs_rx_chk.sv
`timescale 1ns/10ps
module fxpcs_rx_chk (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // inputs
  input wire logic [5:0]            adc_sample,
  input wire logic [2:0]            bypass,
  input wire logic                  rx_ready,
  // outputs
  input wire logic [5:0]            eq_sample_r,
  input wire logic                  lock_r,
  input wire logic                  crs_r,
  input wire logic                  overrun_r,
  input wire logic                  rx_valid_r,
  input wire fxpcs_pkg::fxpcs_nib_t rx_data_r,
  input wire logic                  rx_dv_r,
  input wire logic                  rx_err_r
);
  import fxpcs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // lock must outlive any short glitch: hold timer is far longer
  sequence s_held;
    lock_r [*8];
  endsequence
  chk_eq_delay: assert property (!$past(sys_rst) |->
    eq_sample_r == $past(adc_sample)) else $error("sample copy wrong");
  chk_lock_reset: assert property (disable iff (1'b0)
    sys_rst |=> !lock_r) else $error("lock kept over reset");
  chk_out_reset: assert property (disable iff (1'b0)
    sys_rst |=> !rx_valid_r && !crs_r && !overrun_r)
    else $error("outputs kept over reset");
  chk_lock_late: assert property ($rose(lock_r) && !bypass[1] |->
    !$past(sys_rst, 40)) else $error("lock before 40 bits");
  chk_lock_hold: assert property ($rose(lock_r) |-> s_held)
    else $error("lock dropped early");
  chk_byp_noerr: assert property (rx_valid_r && bypass[2] |->
    !rx_err_r) else $error("error with table off");
  chk_bad_nib: assert property (rx_valid_r && rx_err_r && !rx_dv_r |->
    rx_data_r == 4'he) else $error("bad start nibble wrong");
  chk_word_stands: assert property (rx_valid_r && !rx_ready |=>
    rx_valid_r && $stable({rx_data_r, rx_dv_r, rx_err_r}))
    else $error("word changed while stalled");
endmodule : fxpcs_rx_chk

bind fxpcs_rx fxpcs_rx_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .adc_sample(adc_sample), .bypass(bypass), .rx_ready(rx_ready),
  .eq_sample_r(eq_sample_r), .lock_r(lock_r), .crs_r(crs_r),
  .overrun_r(overrun_r), .rx_valid_r(rx_valid_r), .rx_data_r(rx_data_r),
  .rx_dv_r(rx_dv_r), .rx_err_r(rx_err_r));

// ### verification/fxpcs_line_src.sv
`timescale 1ns/10ps
module fxpcs_line_src (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // plain code bit in, line bit out; raw[0] skips nrzi, raw[1] the key
  input  wire logic       plain,
  input  wire logic [1:0] raw,
  output logic            line_r
);
  logic [10:0] key_r;
  logic        key_nxt;
  logic        scr_bit;
  // keystream x^11+x^9+1, seed nonzero so it never stalls
  assign key_nxt = key_r[10] ^ key_r[8];
  assign scr_bit = raw[1] ? plain : (plain ^ key_nxt);
  // nrzi: a one toggles the line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_r  <= 11'h5a3;
      line_r <= 1'b0;
    end else begin
      key_r  <= {key_r[9:0], key_nxt};
      line_r <= raw[0] ? scr_bit : (line_r ^ scr_bit);
    end
  end
endmodule : fxpcs_line_src

// ### verification/fxpcs_rx_test.sv
`timescale 1ns/10ps
module fxpcs_rx_test;
  import fxpcs_pkg::*;
  // 4b to 5b code table, nibble 0 in the lowest five bits
  localparam logic [79:0] TBL = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16,
    5'h13, 5'h12, 5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
  logic clk, sys_rst, plain, lb_en, rx_ready, sb_on, hold_rdy, src_bit;
  logic [5:0] adc_sample, eq_sample_r;
  logic [2:0] bypass;
  logic [1:0] raw;
  logic lock_r, crs_r, overrun_r, rx_valid_r, rx_dv_r, rx_err_r;
  fxpcs_nib_t rx_data_r;
  logic [6:0] exp_q [$];
  logic [6:0] e;
  int n_fail, n_compared, n_bad;

  fxpcs_line_src u_src (.clk(clk), .sys_rst(sys_rst), .plain(plain),
    .raw(raw), .line_r(src_bit));
  // unselected source carries noise so a wrong select shows
  fxpcs_rx #(.HOLD_CYC(200)) uut (.clk(clk), .sys_rst(sys_rst),
    .line_bit(lb_en ? adc_sample[0] : src_bit),
    .lb_bit(lb_en ? src_bit : adc_sample[1]), .lb_en(lb_en),
    .adc_sample(adc_sample), .eq_sample_r(eq_sample_r), .bypass(bypass),
    .lock_r(lock_r), .crs_r(crs_r), .overrun_r(overrun_r),
    .rx_valid_r(rx_valid_r), .rx_data_r(rx_data_r), .rx_dv_r(rx_dv_r),
    .rx_err_r(rx_err_r), .rx_ready(rx_ready));

  task automatic check(string what, logic [6:0] seen, logic [6:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic put(logic b);
    @(posedge clk);
    plain <= b;
    adc_sample <= 6'($urandom);
    rx_ready <= !hold_rdy && ($urandom % 4 != 0);
  endtask : put
  task automatic send(logic [4:0] g);
    for (int i = 4; i >= 0; i--) put(g[i]);
  endtask : send
  task automatic idle(int n);
    repeat (n) send(5'h1f);
  endtask : idle
  // model frame: two preamble nibbles, data, optional bad group
  task automatic frame(int n, logic bad);
    logic [3:0] d;
    idle(4);
    repeat (n % 3) put(1'b1);
    send(5'h18);
    send(5'h11);
    repeat (2) exp_q.push_back(7'h65);
    for (int i = 0; i < n; i++) begin
      d = 4'($urandom);
      send(TBL[d*5 +: 5]);
      exp_q.push_back({3'b110, bypass[2] ? TBL[d*5 +: 4] : d});
    end
    if (bad) begin
      send(5'h04);
      exp_q.push_back(7'h30);
    end
    send(5'h0d);
    send(5'h07);
    idle(10);
  endtask : frame
  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // scoreboard: frame words in order, bad start words counted
  always @(posedge clk) begin
    if (rx_valid_r === 1'b1 && rx_ready && sb_on) begin
      if (rx_dv_r !== 1'b1) begin
        n_bad++;
        check("bad word", {2'b10, rx_err_r, rx_data_r}, 7'h5e);
      end else if (exp_q.size() == 0) begin
        check("extra word", 7'h7f, 7'h0);
      end else begin
        e = exp_q.pop_front();
        check("rx word", {e[6], rx_dv_r, rx_err_r,
          e[6] ? rx_data_r : 4'h0}, e);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // cut a hang: the run needs about 2400 cycles
  initial begin
    #(30000 * 100);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {sys_rst, plain, sb_on} = 3'b111;
    {lb_en, rx_ready, hold_rdy} = 3'b000;
    adc_sample = 6'h00;
    bypass = 3'h0;
    raw = 2'b00;
    n_fail = 0;
    n_compared = 0;
    n_bad = 0;
    void'($urandom(94));
    repeat (10) @(posedge clk);
    #1 check("lock in reset", {6'h0, lock_r}, 7'h0);
    @(posedge clk) sys_rst <= 1'b0;
    idle(12);
    check("lock", {6'h0, lock_r}, 7'h1);
    idle(100);
    check("lock kept", {6'h0, lock_r}, 7'h1);
    frame(6, 1'b0);
    frame(9, 1'b1);
    bypass <= 3'h4;
    frame(5, 1'b0);
    bypass <= 3'h0;
    repeat (3) send(5'h0a);
    check("carrier", {6'h0, crs_r}, 7'h1);
    idle(10);
    check("bad start", {6'h0, n_bad > 0}, 7'h1);
    check("carrier off", {6'h0, crs_r}, 7'h0);
    repeat (60) send(5'h00);
    check("lock lost", {6'h0, lock_r}, 7'h0);
    idle(12);
    check("relock", {6'h0, lock_r}, 7'h1);
    frame(4, 1'b0);
    // path switch slips bits: wait out hold timer and relock unchecked
    lb_en <= 1'b1;
    sb_on <= 1'b0;
    idle(80);
    sb_on <= 1'b1;
    frame(5, 1'b0);
    check("words left", 7'(exp_q.size()), 7'h0);
    check("no overrun", {6'h0, overrun_r}, 7'h0);
    // nrzi and key stages removed on both ends; idles flush the switch
    raw <= 2'b11;
    bypass <= 3'h3;
    idle(6);
    frame(3, 1'b1);
    check("bypass words", 7'(exp_q.size()), 7'h0);
    // stalled drain: fifo fills and refuses
    hold_rdy <= 1'b1;
    sb_on <= 1'b0;
    frame(20, 1'b0);
    check("overrun", {6'h0, overrun_r}, 7'h1);
    hold_rdy <= 1'b0;
    idle(20);
    check("drained", {5'h0, overrun_r, rx_valid_r}, 7'h2);
    tally_and_finish();
  end
endmodule : fxpcs_rx_test
